// File: rtl/txsw_core.sv
// transmit status write-back: builds descriptor word three, turns the
// transmitter off on fatal errors, and serves the indexed register map
// assumes transmit path events are synchronous one-cycle pulses on mclk
//
// How it works
// - chain error when next buffer unowned or underflow before next status fetch.
// - chain error clears the transmitter-on status bit.
// - every chain error also reports an underflow for that frame.
// - fifo emptied early sets underflow bit 14 and truncates the frame.
// - underflow clears the transmitter-on status bit.
// - reserved bit 13 of word three is always written as zero.
// - with retry disable set, one failed attempt sets retry limit.
// - 10 MHz counter from start to collision or carrier loss, bits 9:0.
// - registers chosen by index, then accessed through the data port.
// - reflection count readable in the 16-bit register at index 94.
// - current status and byte count held at indices 42-43.
// - previous status and byte count held at indices 62-63.
// - scratch register at 68-69 assembles status before write-back.
// - chain error when no end-of-packet and next buffer not owned.
// - with retries enabled, retry limit after 16 failed attempts.
`timescale 1ns/10ps
module txsw_core #(
  parameter int RETRIES = txsw_pkg::RETRY_LIMIT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic index_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  input wire txsw_pkg::txsw_evt_t evt,
  input wire txsw_pkg::txsw_ring_t ring,
  input wire logic [31:0] desc_status_count,
  output logic wb_valid,
  output logic [15:0] wb_word_three,
  output logic transmitter_on,
  output logic fetch_enable,
  output logic truncate
);
  // ==========================================================
  // register port decode
  logic [6:0] index_q;
  logic [15:0] mode_q;
  logic [31:0] cur_q;
  logic [31:0] prev_q;
  logic [31:0] scratch_q;
  logic [txsw_pkg::REFLECT_W-1:0] reflect;
  txsw_pkg::txsw_state_t state_q;
  logic [4:0] attempts_q;
  logic start_req;
  logic retry_disable;
  logic chain_err;
  logic fatal;

  // true when idx selects the word at base or its upper half
  function automatic logic hit32(input logic [6:0] idx, input logic [6:0] base);
    hit32 = (idx == base) || (idx == base + 7'h01);
  endfunction

  // write one half of a 32-bit register picked by the index low bit
  function automatic logic [31:0] put_half(input logic [31:0] old, input logic [6:0] idx,
                                           input logic [15:0] d);
    put_half = idx[0] ? {d, old[15:0]} : {old[31:16], d};
  endfunction

  function automatic logic [15:0] get_half(input logic [31:0] r, input logic [6:0] idx);
    get_half = idx[0] ? r[31:16] : r[15:0];
  endfunction

  assign start_req = data_wr && (index_q == txsw_pkg::IDX_CONTROLLER_STATUS)
                     && wr_data[txsw_pkg::CS_START_BIT];
  assign retry_disable = mode_q[txsw_pkg::MODE_RETRY_DISABLE_BIT];

  // index pointer, then data port access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      index_q <= 7'h00;
    end else if (index_wr) begin
      index_q <= wr_data[6:0];
    end
  end

  // mode register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q <= txsw_pkg::RESET_HALF;
    end else if (data_wr && index_q == txsw_pkg::IDX_OPERATING_MODE) begin
      mode_q <= wr_data;
    end
  end

  // read data is registered; unmapped indices read as zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= txsw_pkg::RESET_HALF;
    end else if (data_rd) begin
      if (index_q == txsw_pkg::IDX_CONTROLLER_STATUS) begin
        rd_data <= 16'(transmitter_on) << txsw_pkg::CS_TRANSMITTER_ON_BIT;
      end else if (index_q == txsw_pkg::IDX_OPERATING_MODE) begin
        rd_data <= mode_q;
      end else if (hit32(index_q, txsw_pkg::IDX_CURRENT_TX_STATUS)) begin
        rd_data <= get_half(cur_q, index_q);
      end else if (hit32(index_q, txsw_pkg::IDX_PREVIOUS_TX_STATUS)) begin
        rd_data <= get_half(prev_q, index_q);
      end else if (hit32(index_q, txsw_pkg::IDX_TX_STATUS_SCRATCH)) begin
        rd_data <= get_half(scratch_q, index_q);
      end else if (index_q == txsw_pkg::IDX_TX_REFLECT) begin
        rd_data <= 16'(reflect);
      end else begin
        rd_data <= txsw_pkg::RESET_HALF;
      end
    end
  end

  // ==========================================================
  // descriptor status and byte count registers
  // hardware loads win over a software write in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_q <= txsw_pkg::RESET_WORD;
    end else if (state_q == txsw_pkg::ST_IDLE && transmitter_on && evt.frame_start) begin
      cur_q <= desc_status_count;
    end else if (data_wr && hit32(index_q, txsw_pkg::IDX_CURRENT_TX_STATUS)) begin
      cur_q <= put_half(cur_q, index_q, wr_data);
    end
  end

  // previous descriptor keeps the value current held before the load
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_q <= txsw_pkg::RESET_WORD;
    end else if (state_q == txsw_pkg::ST_IDLE && transmitter_on && evt.frame_start) begin
      prev_q <= cur_q;
    end else if (data_wr && hit32(index_q, txsw_pkg::IDX_PREVIOUS_TX_STATUS)) begin
      prev_q <= put_half(prev_q, index_q, wr_data);
    end
  end

  // ==========================================================
  // error detection while sending
  // chain error: end of buffer without end-of-packet and next not owned,
  // or underflow before the next status byte was fetched
  assign chain_err = (state_q == txsw_pkg::ST_SEND) &&
                     ((evt.buffer_end && !ring.cur_end_of_packet && !ring.next_owned) ||
                      (evt.underflow && !ring.cur_end_of_packet &&
                       !ring.next_status_fetched));
  assign fatal = chain_err || ((state_q == txsw_pkg::ST_SEND) && evt.underflow);

  // the output is cut short on any fatal error
  assign truncate = fatal;

  // attempt counter for collision retries
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      attempts_q <= 5'h00;
    end else if (state_q == txsw_pkg::ST_IDLE) begin
      attempts_q <= 5'h00;
    end else if (state_q == txsw_pkg::ST_SEND && evt.attempt_fail) begin
      attempts_q <= attempts_q + 5'h01;
    end
  end

  // scratch assembles word three; only a software write sets the reserved bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scratch_q <= txsw_pkg::RESET_WORD;
    end else if (state_q == txsw_pkg::ST_IDLE && transmitter_on && evt.frame_start) begin
      scratch_q <= txsw_pkg::RESET_WORD;
    end else if (state_q == txsw_pkg::ST_SEND) begin
      if (chain_err) begin
        scratch_q[txsw_pkg::W3_BUFFER_CHAIN_BIT] <= 1'b1;
        scratch_q[txsw_pkg::W3_UNDERFLOW_BIT] <= 1'b1;
      end
      if (evt.underflow) begin
        scratch_q[txsw_pkg::W3_UNDERFLOW_BIT] <= 1'b1;
      end
      if (evt.late_collision) begin
        scratch_q[txsw_pkg::W3_LATE_COLL_BIT] <= 1'b1;
      end
      if (evt.carrier_loss) begin
        scratch_q[txsw_pkg::W3_CARRIER_LOSS_BIT] <= 1'b1;
      end
      if (evt.attempt_fail && (retry_disable || attempts_q == 5'(RETRIES - 1))) begin
        scratch_q[txsw_pkg::W3_RETRY_LIMIT_BIT] <= 1'b1;
      end
    end else if (data_wr && hit32(index_q, txsw_pkg::IDX_TX_STATUS_SCRATCH)) begin
      scratch_q <= put_half(scratch_q, index_q, wr_data);
    end
  end

  // ==========================================================
  // frame sequencing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= txsw_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        txsw_pkg::ST_IDLE: begin
          if (transmitter_on && evt.frame_start) begin
            state_q <= txsw_pkg::ST_SEND;
          end
        end
        txsw_pkg::ST_SEND: begin
          if (fatal || evt.late_collision || evt.frame_done ||
              (evt.attempt_fail && (retry_disable || attempts_q == 5'(RETRIES - 1)))) begin
            state_q <= txsw_pkg::ST_WRITEBACK;
          end
        end
        txsw_pkg::ST_WRITEBACK: begin
          state_q <= transmitter_on ? txsw_pkg::ST_IDLE : txsw_pkg::ST_HALT;
        end
        txsw_pkg::ST_HALT: begin
          if (transmitter_on) begin
            state_q <= txsw_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // transmitter on: cleared by fatal errors, set by a software restart;
  // the restart wins so a write racing the error is not lost
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      transmitter_on <= 1'b0;
    end else if (start_req) begin
      transmitter_on <= 1'b1;
    end else if (fatal) begin
      transmitter_on <= 1'b0;
    end
  end

  assign fetch_enable = transmitter_on && (state_q == txsw_pkg::ST_IDLE);

  // write-back of word three, reflection count merged in at the end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_valid <= 1'b0;
      wb_word_three <= txsw_pkg::RESET_HALF;
    end else begin
      wb_valid <= (state_q == txsw_pkg::ST_WRITEBACK);
      if (state_q == txsw_pkg::ST_WRITEBACK) begin
        wb_word_three <= {scratch_q[15:txsw_pkg::W3_RESERVED_BIT+1], 1'b0,
                          scratch_q[txsw_pkg::W3_RESERVED_BIT-1:txsw_pkg::W3_REFLECT_MSB+1],
                          reflect};
      end
    end
  end

  // ==========================================================
  // reflection counter
  txsw_reflect_ctr #(.DIV(txsw_pkg::REFLECT_DIV), .W(txsw_pkg::REFLECT_W)) u_reflect (
    .mclk(mclk),
    .rst(rst),
    .start(state_q == txsw_pkg::ST_IDLE && transmitter_on && evt.frame_start),
    .stop(evt.attempt_fail || evt.late_collision || evt.carrier_loss),
    .count(reflect)
  );

  // ==========================================================
  // checks
  sequence wb_two(int b);
    ##1 (state_q == txsw_pkg::ST_WRITEBACK) ##1 (wb_valid && wb_word_three[b]);
  endsequence

  chain_err_tx_underflow_error_a: assert property (@(posedge mclk) disable iff (rst)
    (wb_valid && wb_word_three[txsw_pkg::W3_BUFFER_CHAIN_BIT])
      |-> wb_word_three[txsw_pkg::W3_UNDERFLOW_BIT])
    else $error("chain error without underflow");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (rst)
    wb_valid |-> !wb_word_three[txsw_pkg::W3_RESERVED_BIT])
    else $error("reserved bit written as one");
  chain_detect_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == txsw_pkg::ST_SEND && evt.buffer_end && !ring.cur_end_of_packet &&
     !ring.next_owned) |-> wb_two(txsw_pkg::W3_BUFFER_CHAIN_BIT))
    else $error("missed chain error");
  tx_underflow_error_set_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == txsw_pkg::ST_SEND && evt.underflow) |-> wb_two(txsw_pkg::W3_UNDERFLOW_BIT))
    else $error("missed underflow");
  txoff_fatal_a: assert property (@(posedge mclk) disable iff (rst)
    (fatal && !start_req) |=> (!transmitter_on && state_q == txsw_pkg::ST_WRITEBACK))
    else $error("transmitter left on after fatal error");
  no_fetch_off_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == txsw_pkg::ST_HALT && !transmitter_on)
      |=> (state_q == txsw_pkg::ST_HALT && !fetch_enable))
    else $error("fetch while halted");
  retry_single_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == txsw_pkg::ST_SEND && evt.attempt_fail && retry_disable && attempts_q == 5'h00)
      |-> wb_two(txsw_pkg::W3_RETRY_LIMIT_BIT))
    else $error("retry disable ignored");
  retry_more_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == txsw_pkg::ST_SEND && evt.attempt_fail && !retry_disable &&
     attempts_q < 5'(RETRIES - 1) && !fatal && !evt.late_collision && !evt.frame_done)
      |=> state_q == txsw_pkg::ST_SEND)
    else $error("retry limit hit early");
  reflect_read_a: assert property (@(posedge mclk) disable iff (rst)
    (data_rd && index_q == txsw_pkg::IDX_TX_REFLECT) |=> rd_data == 16'($past(reflect)))
    else $error("reflect register read wrong");
endmodule

// File: rtl/txsw_pkg.sv
// package for the transmit status write-back block: register indices,
// descriptor word three layout, control bit positions, timing constants
// assumes nothing; every file refers to it as txsw_pkg::name
package txsw_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int REFLECT_PERIOD_NS = 100; // 10 MHz counting rate
  localparam int REFLECT_DIV = REFLECT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RETRY_LIMIT = 16;

  // ==========================================================
  // register index map, reached through the index pointer
  localparam logic [6:0] IDX_CONTROLLER_STATUS = 7'h00;
  localparam logic [6:0] IDX_OPERATING_MODE = 7'h0f;
  localparam logic [6:0] IDX_CURRENT_TX_STATUS = 7'h2a;
  localparam logic [6:0] IDX_PREVIOUS_TX_STATUS = 7'h3e;
  localparam logic [6:0] IDX_TX_STATUS_SCRATCH = 7'h44;
  localparam logic [6:0] IDX_TX_REFLECT = 7'h5e;

  // ==========================================================
  // control and status bits
  localparam int CS_START_BIT = 1; // write one: restart transmission
  localparam int CS_TRANSMITTER_ON_BIT = 4;
  localparam int MODE_RETRY_DISABLE_BIT = 5;

  // ==========================================================
  // descriptor word three fields
  localparam int W3_BUFFER_CHAIN_BIT = 15;
  localparam int W3_UNDERFLOW_BIT = 14;
  localparam int W3_RESERVED_BIT = 13;
  localparam int W3_LATE_COLL_BIT = 12;
  localparam int W3_CARRIER_LOSS_BIT = 11;
  localparam int W3_RETRY_LIMIT_BIT = 10;
  localparam int W3_REFLECT_MSB = 9;
  localparam int REFLECT_W = 10;

  localparam logic [15:0] RESET_HALF = 16'h0000;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // transmit path events, one-cycle pulses
  typedef struct packed {
    logic frame_start;
    logic attempt_fail;
    logic late_collision;
    logic carrier_loss;
    logic underflow;
    logic buffer_end;
    logic frame_done;
  } txsw_evt_t;

  // descriptor ring view, levels
  typedef struct packed {
    logic cur_end_of_packet;
    logic next_owned;
    logic next_status_fetched;
  } txsw_ring_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WRITEBACK, ST_HALT} txsw_state_t;
endpackage

// File: rtl/txsw_reflect_ctr.sv
// cable reflection counter: counts at the slow reflect rate from the
// start of a transmission until a collision or loss of carrier
// assumes start and stop are single-cycle pulses on mclk
`timescale 1ns/10ps
module txsw_reflect_ctr #(
  parameter int DIV = txsw_pkg::REFLECT_DIV,
  parameter int W = txsw_pkg::REFLECT_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  output logic [W-1:0] count
);
  // ==========================================================
  // prescaler and counter
  logic [7:0] pre_q;
  logic run_q;
  logic tick;
  assign tick = run_q && (pre_q == 8'(DIV - 1));

  // run from start until the first stop event
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_q <= 1'b0;
    end else if (start) begin
      run_q <= 1'b1;
    end else if (stop) begin
      run_q <= 1'b0;
    end
  end

  // divide the system clock down to the counting rate
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_q <= 8'h00;
    end else if (start || tick) begin
      pre_q <= 8'h00;
    end else if (run_q) begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // count saturates rather than wraps: a wrapped value would lie
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (start) begin
      count <= '0;
    end else if (tick && !stop && (count != '1)) begin
      count <= count + W'(1);
    end
  end

  // ==========================================================
  // checks
  ctr_tick_step_a: assert property (@(posedge mclk) disable iff (rst)
    (tick && !stop && !start && count != '1) |=> count == $past(count) + W'(1))
    else $error("reflect count did not step on tick");
  ctr_frozen_a: assert property (@(posedge mclk) disable iff (rst)
    (!run_q && !start) |=> $stable(count))
    else $error("reflect count moved while stopped");
endmodule

// File: bench/txsw_host_model.sv
// host side stand-in: descriptor ring view and the fetched status word
// assumes the bench picks the ring state and the next descriptor value
`timescale 1ns/10ps
module txsw_host_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fetch_enable,
  input wire logic [2:0] ring_cfg,
  input wire logic [31:0] new_desc,
  output txsw_pkg::txsw_ring_t ring,
  output logic [31:0] desc_status_count
);
  // ==========================================================
  // descriptor fetch
  // only fetched while the device may fetch, so a halted device sees no new word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      desc_status_count <= 32'h0000_0000;
    end else if (fetch_enable) begin
      desc_status_count <= new_desc;
    end
  end

  // ownership, end-of-packet and status-fetch levels as the bench orders
  assign ring = txsw_pkg::txsw_ring_t'(ring_cfg);
endmodule

// File: bench/tx_descriptor_status_writeback_test.sv
// self-checking bench for the transmit status write-back core
// assumes the host model stands in for the descriptor ring
`timescale 1ns/10ps
module tx_descriptor_status_writeback_test;
  localparam int E_START = 6;
  localparam int E_FAIL = 5;
  localparam int E_LATE = 4;
  localparam int E_CARR = 3;
  localparam int E_UF = 2;
  localparam int E_BEND = 1;
  localparam int E_DONE = 0;
  logic mclk, rst, index_wr, data_wr, data_rd, wb_valid, transmitter_on, fetch_enable;
  logic truncate, tr;
  logic [15:0] wr_data, rd_data, wb_word_three, rv, w3;
  logic [2:0] ring_cfg;
  logic [31:0] desc_status_count, new_desc;
  logic [31:0] desc_q[$];
  txsw_pkg::txsw_evt_t evt;
  txsw_pkg::txsw_ring_t ring;
  int mismatches, samples_checked, wb_cnt, seed;

  // ==========================================================
  // clock, instances
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  txsw_core u_txsw_core (.mclk(mclk), .rst(rst), .index_wr(index_wr), .data_wr(data_wr),
    .data_rd(data_rd), .wr_data(wr_data), .rd_data(rd_data), .evt(evt), .ring(ring),
    .desc_status_count(desc_status_count), .wb_valid(wb_valid),
    .wb_word_three(wb_word_three), .transmitter_on(transmitter_on),
    .fetch_enable(fetch_enable), .truncate(truncate));
  txsw_host_model u_txsw_host_model (.mclk(mclk), .rst(rst), .fetch_enable(fetch_enable),
    .ring_cfg(ring_cfg), .new_desc(new_desc), .ring(ring),
    .desc_status_count(desc_status_count));
  // write-back pulses seen, to prove that nothing was written early
  always @(posedge mclk) if (wb_valid === 1'b1) wb_cnt++;

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic reg_acc(input logic [6:0] idx, input logic wr, input logic [15:0] d);
    @(posedge mclk); #1 index_wr = 1'b1; wr_data = {9'h000, idx};
    @(posedge mclk); #1 index_wr = 1'b0; data_wr = wr; data_rd = ~wr; wr_data = d;
    @(posedge mclk); #1 data_wr = 1'b0; data_rd = 1'b0;
    rv = rd_data;
  endtask
  // one-cycle event pulse; truncate is a same-cycle level, so look mid-cycle
  task automatic ev(input int b);
    @(posedge mclk); #1 evt = txsw_pkg::txsw_evt_t'(7'h01 << b);
    @(negedge mclk); tr = truncate;
    @(posedge mclk); #1 evt = '0;
  endtask
  // full frame: optional mid-frame event, reps of the ending event
  task automatic frame(input int pre, input int term, input int reps, input logic [5:0] e6,
                       input logic trunc);
    int n, c;
    @(posedge mclk);
    #1 new_desc = $random(seed);
    ev(E_START);
    desc_q.push_back(new_desc);
    repeat (53) @(posedge mclk);
    if (pre >= 0) ev(pre);
    c = wb_cnt;
    for (n = 1; n < reps; n++) ev(term);
    chk(wb_cnt, c);
    ev(term);
    chk(tr, trunc);
    n = 0;
    while (wb_valid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 20, 1);
    w3 = wb_word_three;
    chk(w3[15:10], e6);
    // reflection count only trusted with the retry flag
    if (e6[0]) chk(w3[9:0] >= 10'd4 && w3[9:0] <= 10'd6, 1);
  endtask
  task automatic halted;
    int c;
    @(negedge mclk);
    chk({transmitter_on, fetch_enable}, 2'b00);
    reg_acc(txsw_pkg::IDX_CONTROLLER_STATUS, 1'b0, 16'h0000);
    chk(rv[txsw_pkg::CS_TRANSMITTER_ON_BIT], 0);
    c = wb_cnt;
    ev(E_START);
    repeat (8) @(posedge mclk);
    chk(wb_cnt, c);
    chk(fetch_enable, 0);
    reg_acc(txsw_pkg::IDX_CONTROLLER_STATUS, 1'b1, 16'h0002);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h081d;
    {rst, index_wr, data_wr, data_rd, wr_data, new_desc} = {1'b1, 51'h0};
    evt = '0;
    ring_cfg = 3'b110;
    repeat (20) @(posedge mclk);
    #1 rst = 1'b0;
    chk({transmitter_on, fetch_enable, wb_valid}, 3'b000);
    reg_acc(txsw_pkg::IDX_CONTROLLER_STATUS, 1'b1, 16'h0002);
    chk({transmitter_on, fetch_enable}, 2'b11);
    frame(-1, E_DONE, 1, 6'h00, 0);
    frame(E_BEND, E_DONE, 1, 6'h00, 0);
    // current and previous status words, two halves each
    reg_acc(txsw_pkg::IDX_CURRENT_TX_STATUS, 1'b0, 16'h0000);
    chk(rv, desc_q[$][15:0]);
    reg_acc(txsw_pkg::IDX_CURRENT_TX_STATUS + 7'h01, 1'b0, 16'h0000);
    chk(rv, desc_q[$][31:16]);
    reg_acc(txsw_pkg::IDX_PREVIOUS_TX_STATUS, 1'b0, 16'h0000);
    chk(rv, desc_q[$-1][15:0]);
    reg_acc(txsw_pkg::IDX_PREVIOUS_TX_STATUS + 7'h01, 1'b0, 16'h0000);
    chk(rv, desc_q[$-1][31:16]);
    new_desc = $random(seed);
    reg_acc(txsw_pkg::IDX_TX_STATUS_SCRATCH + 7'h01, 1'b1, new_desc[15:0]);
    reg_acc(txsw_pkg::IDX_TX_STATUS_SCRATCH + 7'h01, 1'b0, 16'h0000);
    chk(rv, new_desc[15:0]);
    reg_acc(7'h10, 1'b0, 16'h0000);
    chk(rv, 16'h0000);
    // retry disabled: first failure ends it
    reg_acc(txsw_pkg::IDX_OPERATING_MODE, 1'b1, 16'h0020);
    frame(-1, E_FAIL, 1, 6'h01, 0);
    reg_acc(txsw_pkg::IDX_TX_REFLECT, 1'b1, ~w3);
    reg_acc(txsw_pkg::IDX_TX_REFLECT, 1'b0, 16'h0000);
    chk(rv, {6'h00, w3[9:0]});
    chk(rv >= 16'd4 && rv <= 16'd6, 1);
    reg_acc(txsw_pkg::IDX_OPERATING_MODE, 1'b1, 16'h0000);
    frame(-1, E_FAIL, 16, 6'h01, 0);
    frame(-1, E_LATE, 1, 6'h04, 0);
    frame(E_CARR, E_DONE, 1, 6'h02, 0);
    chk(transmitter_on, 1);
    frame(-1, E_UF, 1, 6'h10, 1);
    halted;
    ring_cfg = 3'b000;
    frame(-1, E_UF, 1, 6'h30, 1);
    halted;
    frame(-1, E_BEND, 1, 6'h30, 1);
    halted;
    // status byte already fetched: late data is a plain underflow
    ring_cfg = 3'b001;
    frame(-1, E_UF, 1, 6'h10, 1);
    halted;
    ring_cfg = 3'b110;
    frame(-1, E_DONE, 1, 6'h00, 0);
    report_and_stop;
  end

  // hang guard, several times the expected run length
  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end
endmodule
